// file: core/adcdo_regs.svh
// register offsets, field positions, reset values and timing counts of the output-configuration block
// assumes: included by bare name from the core and the bench; registers are word-spaced (byte = 4 x index)
`ifndef ADCDO_REGS_SVH
`define ADCDO_REGS_SVH

`define ADCDO_IDX_IFSEL     8'h41
`define ADCDO_IDX_CTL       8'h50
`define ADCDO_IDX_CPLO      8'h51
`define ADCDO_IDX_CPHI      8'h52
`define ADCDO_IDX_CEN       8'h53
`define ADCDO_IDX_GTC       8'h55
`define ADCDO_IDX_FGAIN     8'h57
`define ADCDO_IDX_PAT       8'h62
`define ADCDO_IDX_PED       8'h63
`define ADCDO_IDX_STAT      8'h64

`define ADCDO_MASK_IFSEL    8'h80
`define ADCDO_MASK_CTL      8'h46
`define ADCDO_MASK_CPLO     8'hF8
`define ADCDO_MASK_CPHI     8'h3F
`define ADCDO_MASK_CEN      8'h40
`define ADCDO_MASK_GTC      8'hFF
`define ADCDO_MASK_FGAIN    8'h7F
`define ADCDO_MASK_PAT      8'h07
`define ADCDO_MASK_PED      8'h38

`define ADCDO_RST_REG       8'h00

`define ADCDO_BIT_LVDS      7
`define ADCDO_BIT_IND       6
`define ADCDO_BIT_OFFBIN    1
`define ADCDO_BIT_CEN       6

`define ADCDO_TC_BASE       262144
`define ADCDO_TC_MAX        4'hB
`define ADCDO_MIDCODE       13'sh0400
`define ADCDO_RAMP_DIV_LAST 3'h7
`define ADCDO_TOGGLE_WORD   11'h2AA

`endif

// file: core/adcdo_pkg.sv
// types shared by the output-configuration block
// assumes: the register header sits beside this file
package adcdo_pkg;
  typedef logic [10:0] adcdo_word_t;
  typedef logic [7:0]  adcdo_reg_t;
  typedef enum logic [2:0]
  {
    ADCDO_PAT_NORMAL = 3'h0,
    ADCDO_PAT_ZEROS  = 3'h1,
    ADCDO_PAT_ONES   = 3'h2,
    ADCDO_PAT_TOGGLE = 3'h3,
    ADCDO_PAT_RAMP   = 3'h4,
    ADCDO_PAT_CUSTOM = 3'h5,
    ADCDO_PAT_UNUSED6 = 3'h6,
    ADCDO_PAT_UNUSED7 = 3'h7
  } adcdo_pat_t;
endpackage

// file: core/adcdo_core.sv
// output-configuration registers and digital output path of a dual-channel 11-bit converter
// assumes: Avalon-MM master on clk; sample clock and converter words arrive from outside the clk domain
//
// Operation
// - control-select bit 0 shares settings; 1 gives channel B its own defaults.
// - format code 10 emits twos complement, code 11 offset binary.
// - low custom register keeps five low pattern bits in bits 7 to 3.
// - high custom register keeps six high pattern bits in bits 5 to 0.
// - correction enable turns loop on; both channels shared, channel A if separate.
// - four-bit coarse gain, 0.5 dB steps, 0 dB at reset up to 6 dB.
// - time-constant code sets loop period, 256k cycles doubling up to 512M.
// - seven-bit fine gain adds 20log10(1+code/1024) dB on top of coarse gain.
// - pattern 000 passes data, 001 all zeros, 010 all ones; 110, 111 unused.
// - pattern 011 alternates 01010101010 and 10101010101 each sample.
// - pattern 100 ramps 0 to 2047, one step every eighth sample.
// - pattern 101 sends the custom word instead of converter data.
// - LVDS sends 12 bits with a zero dummy bit as least significant bit.
// - LVDS even bits follow output clock rise, odd bits its fall.
// - toggle pattern changes each line at half the sample rate.
// - enabled correction pulls output toward 1024 plus pedestal.
// - pedestal is signed three bits, +3 at 011 down to -4 at 100.
// - interface bit selects parallel CMOS at 0, DDR LVDS at 1.
`timescale 1ns/1ps
`include "adcdo_regs.svh"

module adcdo_core
  import adcdo_pkg::*;
#(
  parameter int unsigned TC_BASE = `ADCDO_TC_BASE
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sample_clk,
  input  wire logic [10:0] conv_a_in,
  input  wire logic [10:0] conv_b_in,
  output logic             output_clock_pos,
  output logic [10:0]      cmos_a_out,
  output logic [10:0]      cmos_b_out,
  output logic [5:0]       lvds_a_out,
  output logic [5:0]       lvds_b_out
);

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Q10 coarse gain factors, 10^(code*0.5/20)
  function automatic logic [11:0] adcdo_coarse(input logic [3:0] code);
    logic [11:0] f;
    f = 12'h400;
    case (code)
      4'h1: f = 12'd1085;
      4'h2: f = 12'd1149;
      4'h3: f = 12'd1217;
      4'h4: f = 12'd1289;
      4'h5: f = 12'd1366;
      4'h6: f = 12'd1446;
      4'h7: f = 12'd1532;
      4'h8: f = 12'd1623;
      4'h9: f = 12'd1719;
      4'hA: f = 12'd1821;
      4'hB: f = 12'd1929;
      4'hC: f = 12'd2043;
      default: f = 12'h400;
    endcase
    return f;
  endfunction

  // signed sample around mid-scale, scaled and saturated back to offset binary
  function automatic adcdo_word_t adcdo_gain(input logic signed [12:0] s, input logic [3:0] cg,
                                             input logic [6:0] fg);
    logic signed [37:0] p;
    logic signed [37:0] q;
    logic        [11:0] fm;
    fm = 12'h400 + {5'h00, fg};
    p  = 38'(s) * 38'($signed({1'b0, adcdo_coarse(cg)})) * 38'($signed({1'b0, fm}));
    q  = p >>> 20;
    if (q > 38'sd1023)
      return 11'h7FF;
    else if (q < -38'sd1024)
      return 11'h000;
    else
      return 11'(q + 38'sd1024);
  endfunction

  // registers
  adcdo_reg_t ifsel_q, ctl_q, cplo_q, cphi_q, cen_q, gtc_q, fgain_q, pat_q, ped_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [7:0]  idx;
  logic        req;
  logic        wr_lane;

  assign idx             = avs_address[9:2];
  assign req             = avs_read | avs_write;
  assign wr_lane         = avs_write & ack_q & avs_byteenable[0];
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  // one wait state: data is fetched on the first edge, taken on the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // reserved bits are masked off, so stray ones read back as zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ifsel_q <= `ADCDO_RST_REG;
      ctl_q   <= `ADCDO_RST_REG;
      cplo_q  <= `ADCDO_RST_REG;
      cphi_q  <= `ADCDO_RST_REG;
      cen_q   <= `ADCDO_RST_REG;
      gtc_q   <= `ADCDO_RST_REG;
      fgain_q <= `ADCDO_RST_REG;
      pat_q   <= `ADCDO_RST_REG;
      ped_q   <= `ADCDO_RST_REG;
    end
    else if (wr_lane)
    begin
      case (idx)
        `ADCDO_IDX_IFSEL: ifsel_q <= avs_writedata[7:0] & `ADCDO_MASK_IFSEL;
        `ADCDO_IDX_CTL:   ctl_q   <= avs_writedata[7:0] & `ADCDO_MASK_CTL;
        `ADCDO_IDX_CPLO:  cplo_q  <= avs_writedata[7:0] & `ADCDO_MASK_CPLO;
        `ADCDO_IDX_CPHI:  cphi_q  <= avs_writedata[7:0] & `ADCDO_MASK_CPHI;
        `ADCDO_IDX_CEN:   cen_q   <= avs_writedata[7:0] & `ADCDO_MASK_CEN;
        `ADCDO_IDX_GTC:   gtc_q   <= avs_writedata[7:0] & `ADCDO_MASK_GTC;
        `ADCDO_IDX_FGAIN: fgain_q <= avs_writedata[7:0] & `ADCDO_MASK_FGAIN;
        `ADCDO_IDX_PAT:   pat_q   <= avs_writedata[7:0] & `ADCDO_MASK_PAT;
        `ADCDO_IDX_PED:   ped_q   <= avs_writedata[7:0] & `ADCDO_MASK_PED;
        default:          ;
      endcase
    end
  end

  logic signed [10:0] off_q [2];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read & ~ack_q)
    begin
      case (idx)
        `ADCDO_IDX_IFSEL: rdata_q <= {24'h000000, ifsel_q};
        `ADCDO_IDX_CTL:   rdata_q <= {24'h000000, ctl_q};
        `ADCDO_IDX_CPLO:  rdata_q <= {24'h000000, cplo_q};
        `ADCDO_IDX_CPHI:  rdata_q <= {24'h000000, cphi_q};
        `ADCDO_IDX_CEN:   rdata_q <= {24'h000000, cen_q};
        `ADCDO_IDX_GTC:   rdata_q <= {24'h000000, gtc_q};
        `ADCDO_IDX_FGAIN: rdata_q <= {24'h000000, fgain_q};
        `ADCDO_IDX_PAT:   rdata_q <= {24'h000000, pat_q};
        `ADCDO_IDX_PED:   rdata_q <= {24'h000000, ped_q};
        `ADCDO_IDX_STAT:  rdata_q <= {21'h0, off_q[0]};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // sample clock and converter words cross in through two flops each
  logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic [1:0][10:0] conv_s1_q, conv_s2_q;
  logic       s_rise, s_fall;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      conv_s1_q <= '0;
      conv_s2_q <= '0;
    end
    else
    begin
      sclk_s1_q <= sample_clk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      conv_s1_q <= {conv_b_in, conv_a_in};
      conv_s2_q <= conv_s1_q;
    end
  end

  assign s_rise = sclk_s2_q & ~sclk_s3_q;
  assign s_fall = ~sclk_s2_q & sclk_s3_q;

  // per-channel settings; channel B falls back to defaults under separate control
  logic              ind, lvds_mode;
  adcdo_pat_t        pat_ch [2];
  logic              cen_ch [2];
  logic signed [2:0] ped_ch [2];
  logic [3:0]        cg_ch  [2];
  logic [6:0]        fg_ch  [2];
  logic [3:0]        tc_ch  [2];

  assign ind       = ctl_q[`ADCDO_BIT_IND];
  assign lvds_mode = ifsel_q[`ADCDO_BIT_LVDS];

  always_comb
  begin
    pat_ch[0] = adcdo_pat_t'(pat_q[2:0]);
    cen_ch[0] = cen_q[`ADCDO_BIT_CEN];
    ped_ch[0] = $signed(ped_q[5:3]);
    cg_ch[0]  = gtc_q[7:4];
    fg_ch[0]  = fgain_q[6:0];
    tc_ch[0]  = (gtc_q[3:0] > `ADCDO_TC_MAX) ? `ADCDO_TC_MAX : gtc_q[3:0];
    pat_ch[1] = ind ? ADCDO_PAT_NORMAL : pat_ch[0];
    cen_ch[1] = ind ? 1'b0 : cen_ch[0];
    ped_ch[1] = ind ? 3'sh0 : ped_ch[0];
    cg_ch[1]  = ind ? 4'h0 : cg_ch[0];
    fg_ch[1]  = ind ? 7'h00 : fg_ch[0];
    tc_ch[1]  = tc_ch[0];
  end

  // pattern sources, stepped once per sample; the ramp moves once every eighth sample
  logic        tog_q;
  logic [10:0] ramp_q;
  logic [2:0]  rdiv_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tog_q  <= 1'b0;
      ramp_q <= 11'h000;
      rdiv_q <= 3'h0;
    end
    else if (s_rise)
    begin
      tog_q  <= ~tog_q;
      rdiv_q <= rdiv_q + 3'h1;
      if (rdiv_q == `ADCDO_RAMP_DIV_LAST)
        ramp_q <= ramp_q + 11'h001;
    end
  end

  // correction loop: integrate error for one period, then nudge offset one LSB
  logic signed [12:0] corr   [2];
  logic signed [12:0] err    [2];
  logic signed [42:0] acc_q  [2];
  logic        [29:0] cnt_q  [2];
  logic        [29:0] period [2];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      corr[c]   = $signed({2'b00, conv_s2_q[c]}) - 13'(off_q[c]);
      err[c]    = corr[c] - (`ADCDO_MIDCODE + 13'(ped_ch[c]));
      period[c] = 30'(TC_BASE) << tc_ch[c];
    end
  end

  always_ff @(posedge clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (sys_rst || !cen_ch[c])
      begin
        off_q[c] <= 11'sh000;
        acc_q[c] <= 43'sh0;
        cnt_q[c] <= 30'h0;
      end
      else if (s_rise)
      begin
        if (cnt_q[c] >= period[c] - 30'h1)
        begin
          cnt_q[c] <= 30'h0;
          acc_q[c] <= 43'sh0;
          if (acc_q[c] > 43'sh0 && off_q[c] != 11'sh3FF)
            off_q[c] <= off_q[c] + 11'sh001;
          else if (acc_q[c] < 43'sh0 && off_q[c] != -11'sh400)
            off_q[c] <= off_q[c] - 11'sh001;
        end
        else
        begin
          cnt_q[c] <= cnt_q[c] + 30'h1;
          acc_q[c] <= acc_q[c] + 43'(err[c]);
        end
      end
    end
  end

  // next 12-bit word: 11 data bits over a dummy bit that is always zero
  logic [11:0] word_d [2];
  logic [11:0] word_q [2];
  adcdo_word_t data   [2], gain_w [2];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      gain_w[c] = adcdo_gain(corr[c] - `ADCDO_MIDCODE, cg_ch[c], fg_ch[c]);
      data[c]   = gain_w[c];
      if (!ctl_q[`ADCDO_BIT_OFFBIN])
        data[c] = data[c] ^ 11'h400;
      unique case (pat_ch[c])
        ADCDO_PAT_NORMAL: word_d[c] = {data[c], 1'b0};
        ADCDO_PAT_ZEROS:  word_d[c] = 12'h000;
        ADCDO_PAT_ONES:   word_d[c] = {11'h7FF, 1'b0};
        ADCDO_PAT_TOGGLE: word_d[c] = {tog_q ? ~`ADCDO_TOGGLE_WORD : `ADCDO_TOGGLE_WORD, 1'b0};
        ADCDO_PAT_RAMP:   word_d[c] = {ramp_q, 1'b0};
        ADCDO_PAT_CUSTOM: word_d[c] = {cphi_q[5:0], cplo_q[7:3], 1'b0};
        default:          word_d[c] = {data[c], 1'b0};
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (sys_rst)
        word_q[c] <= 12'h000;
      else if (s_rise)
        word_q[c] <= word_d[c];
    end
  end

  // output stage; the regenerated output clock is one clk behind the sampled edge, as is the data
  function automatic logic [5:0] adcdo_lanes(input logic [11:0] w, input logic odd);
    logic [5:0] l;
    for (int i = 0; i < 6; i++)
      l[i] = w[2 * i + int'(odd)];
    return l;
  endfunction

  logic       oclk_q;
  logic [5:0] lv_q [2];
  logic [10:0] cm_q [2];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      oclk_q <= 1'b0;
    else
      oclk_q <= sclk_s2_q;
  end

  always_ff @(posedge clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (sys_rst)
      begin
        lv_q[c] <= 6'h00;
        cm_q[c] <= 11'h000;
      end
      else if (lvds_mode)
      begin
        cm_q[c] <= 11'h000;
        if (s_rise)
          lv_q[c] <= adcdo_lanes(word_d[c], 1'b0);
        else if (s_fall)
          lv_q[c] <= adcdo_lanes(word_q[c], 1'b1);
      end
      else
      begin
        lv_q[c] <= 6'h00;
        if (s_rise)
          cm_q[c] <= word_d[c][11:1];
      end
    end
  end

  assign output_clock_pos = oclk_q;
  assign cmos_a_out       = cm_q[0];
  assign cmos_b_out       = cm_q[1];
  assign lvds_a_out       = lv_q[0];
  assign lvds_b_out       = lv_q[1];

  // checks
  sep_ctl_a: assert property (s_rise && ind && lvds_mode == 1'b0 |=> cm_q[1] == word_q[1][11:1]
    && (word_q[1] == {$past(data[1]), 1'b0})) else $error("channel B left normal path");
  fmt_sel_a: assert property (s_rise && pat_ch[0] == ADCDO_PAT_NORMAL && !ctl_q[`ADCDO_BIT_OFFBIN]
    |=> word_q[0][11:1] == ($past(gain_w[0]) ^ 11'h400)) else $error("format wrong");
  zeros_pat_a: assert property (s_rise && pat_ch[0] == ADCDO_PAT_ZEROS |=> word_q[0] == 12'h000)
    else $error("zeros pattern wrong");
  ones_pat_a: assert property (s_rise && pat_ch[0] == ADCDO_PAT_ONES |=> word_q[0] == 12'hFFE)
    else $error("ones pattern wrong");
  toggle_pat_a: assert property (s_rise && pat_ch[0] == ADCDO_PAT_TOGGLE && (word_q[0] == 12'h554
    || word_q[0] == 12'hAAA) |=> word_q[0] == ($past(word_q[0]) ^ 12'hFFE)) else $error("toggle pattern wrong");
  ramp_step_a: assert property (s_rise && pat_ch[0] == ADCDO_PAT_RAMP && rdiv_q == 3'h7
    |=> ramp_q == $past(ramp_q) + 11'h001 ##0 word_q[0][11:1] == $past(ramp_q)) else $error("ramp step wrong");
  custom_pat_a: assert property (s_rise && pat_ch[0] == ADCDO_PAT_CUSTOM
    |=> word_q[0] == {cphi_q[5:0], cplo_q[7:3], 1'b0}) else $error("custom pattern wrong");
  dummy_zero_a: assert property (word_q[0][0] == 1'b0 && word_q[1][0] == 1'b0)
    else $error("dummy bit set");
  lvds_odd_a: assert property (lvds_mode && $past(lvds_mode) && s_fall
    |=> lv_q[0] == {word_q[0][11], word_q[0][9], word_q[0][7], word_q[0][5], word_q[0][3], word_q[0][1]})
    else $error("odd lanes wrong");
  corr_off_a: assert property (!cen_ch[0] |=> off_q[0] == 11'sh000 && acc_q[0] == 43'sh0)
    else $error("correction not off");
  period_cap_a: assert property (cen_ch[0] |-> cnt_q[0] < period[0] || $changed(gtc_q))
    else $error("period overrun");
  cmos_out_a: assert property (!lvds_mode && s_rise ##1 !lvds_mode |-> cm_q[0] == word_q[0][11:1]
    && lv_q[0] == 6'h00) else $error("cmos output wrong");

endmodule

// file: test/adcdo_capture_model.sv
// capture-side model of the data receiver: rebuilds channel A words from the CMOS bus or the DDR lanes
// assumes: output clock and data leave on the same clk edge, so edges are found one clk later
`timescale 1ns/1ps
module adcdo_capture_model
  import adcdo_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        output_clock_pos,
  input  wire logic [10:0] cmos_a_out,
  input  wire logic [5:0]  lvds_a_out,
  output adcdo_word_t      rx_cmos_q,
  output adcdo_word_t      rx_lvds_q,
  output logic             rx_dummy_q,
  output logic [15:0]      rx_cnt_q
);
  logic        oclk_prev_q;
  logic [5:0]  even_q;
  logic [11:0] word12;
  logic        rise;
  logic        fall;

  assign rise = output_clock_pos && !oclk_prev_q;
  assign fall = !output_clock_pos && oclk_prev_q;

  always_ff @(posedge clk)
    oclk_prev_q <= sys_rst ? 1'b0 : output_clock_pos;

  // even lanes are only valid between rise and fall
  always_ff @(posedge clk)
    if (sys_rst)
      even_q <= 6'h00;
    else if (rise)
      even_q <= lvds_a_out;

  always_ff @(posedge clk)
    if (sys_rst)
      rx_cmos_q <= 11'h000;
    else if (rise)
      rx_cmos_q <= cmos_a_out;

  always_comb
    for (int i = 0; i < 6; i++)
    begin
      word12[2*i]   = even_q[i];
      word12[2*i+1] = lvds_a_out[i];
    end

  // dummy kept apart only so the bench can look at it
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      rx_lvds_q  <= 11'h000;
      rx_dummy_q <= 1'b0;
    end
    else if (fall)
    begin
      rx_lvds_q  <= word12[11:1];
      rx_dummy_q <= word12[0];
    end

  always_ff @(posedge clk)
    if (sys_rst)
      rx_cnt_q <= 16'h0000;
    else if (fall)
      rx_cnt_q <= rx_cnt_q + 16'h0001;
endmodule

// file: test/adcdo_core_bench.sv
// self-checking bench of the output-configuration block: Avalon tasks plus sample-by-sample capture
// assumes: one Avalon master on clk, sample clock of 400 ns made here, loop period shortened to 16
`timescale 1ns/1ps
`include "adcdo_regs.svh"
module adcdo_core_bench
  import adcdo_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sample_clk = 1'b0;
  logic [10:0] conv_a_in = 11'h000;
  logic [10:0] conv_b_in = 11'h000;
  logic        output_clock_pos;
  logic [10:0] cmos_a_out;
  logic [10:0] cmos_b_out;
  logic [5:0]  lvds_a_out;
  logic [5:0]  lvds_b_out;
  adcdo_word_t rx_cmos_q;
  adcdo_word_t rx_lvds_q;
  logic        rx_dummy_q;
  logic [15:0] rx_cnt_q;
  logic [31:0] rd;
  adcdo_word_t w0;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [7:0]  idx_tab [9] = '{8'h41, 8'h50, 8'h51, 8'h52, 8'h53, 8'h55, 8'h57, 8'h62, 8'h63};
  logic [7:0]  msk_tab [9] = '{8'h80, 8'h46, 8'hF8, 8'h3F, 8'h40, 8'hFF, 8'h7F, 8'h07, 8'h38};

  always #25 clk = ~clk;

  // sample clock locked to clk edges keeps the driving race-free
  always
  begin
    repeat (4) @(posedge clk);
    sample_clk <= ~sample_clk;
  end

  adcdo_core #(.TC_BASE(16)) i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_clk(sample_clk),
    .conv_a_in(conv_a_in), .conv_b_in(conv_b_in), .output_clock_pos(output_clock_pos), .cmos_a_out(cmos_a_out),
    .cmos_b_out(cmos_b_out), .lvds_a_out(lvds_a_out), .lvds_b_out(lvds_b_out));

  adcdo_capture_model i_rx (.clk(clk), .sys_rst(sys_rst), .output_clock_pos(output_clock_pos),
    .cmos_a_out(cmos_a_out), .lvds_a_out(lvds_a_out), .rx_cmos_q(rx_cmos_q), .rx_lvds_q(rx_lvds_q),
    .rx_dummy_q(rx_dummy_q), .rx_cnt_q(rx_cnt_q));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // gain and loop results are checked to a small window, rounding is the designer's
  task automatic check_near(input string name, input logic [11:0] exp, input logic [11:0] tol,
                            input logic [10:0] got);
    num_checks++;
    if (({1'b0, got} >= exp - tol && {1'b0, got} <= exp + tol) !== 1'b1)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until the rising edge that samples waitrequest low; data taken and request dropped there
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= {idx, 2'h0};
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0)
      check("bus_answer", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus_xfer(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd_check(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus_xfer(1'b0, idx, 8'h00, 4'hF);
    check(name, {24'h000000, exp}, rd);
  endtask

  task automatic next_word(input int n);
    logic [15:0] c;
    int k;
    repeat (n)
    begin
      c = rx_cnt_q;
      k = 0;
      do
      begin
        @(negedge clk);
        k++;
      end
      while (rx_cnt_q === c && k < 100);
      if (k >= 100)
        check("sample_flow", 32'h0, 32'h1);
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      rd_check("reg_reset", idx_tab[i], 8'h00);
      wr(idx_tab[i], msk_tab[i]);
      rd_check("reg_mask", idx_tab[i], msk_tab[i]);
    end
    wr(8'h70, 8'hFF);
    rd_check("unmapped", 8'h70, 8'h00);
    wr(`ADCDO_IDX_FGAIN, 8'h00);
    bus_xfer(1'b1, `ADCDO_IDX_FGAIN, 8'h55, 4'h0);
    rd_check("byteenable_off", `ADCDO_IDX_FGAIN, 8'h00);
    for (int i = 0; i < 9; i++)
      wr(idx_tab[i], 8'h00);
    $display("test registers done");

    conv_a_in <= 11'h123;
    conv_b_in <= 11'h456;
    wr(`ADCDO_IDX_CTL, 8'h06);
    next_word(3);
    check("offset_binary", 32'h123, rx_cmos_q);
    check("normal_b", 32'h456, cmos_b_out);
    wr(`ADCDO_IDX_CTL, 8'h04);
    next_word(3);
    check("twos_complement", 32'h523, rx_cmos_q);
    wr(`ADCDO_IDX_CTL, 8'h06);
    wr(`ADCDO_IDX_PAT, ADCDO_PAT_ZEROS);
    next_word(3);
    check("all_zeros", 32'h000, rx_cmos_q);
    wr(`ADCDO_IDX_PAT, ADCDO_PAT_ONES);
    next_word(3);
    check("all_ones", 32'h7FF, rx_cmos_q);
    wr(`ADCDO_IDX_PAT, ADCDO_PAT_TOGGLE);
    next_word(3);
    w0 = rx_cmos_q;
    check("toggle_word", 32'h1, 32'(w0 === 11'h2AA || w0 === 11'h555));
    next_word(1);
    check("toggle_next", {21'h0, ~w0}, rx_cmos_q);
    wr(`ADCDO_IDX_PAT, ADCDO_PAT_RAMP);
    next_word(3);
    w0 = rx_cmos_q;
    next_word(8);
    check("ramp_step", {21'h0, w0 + 11'h001}, rx_cmos_q);
    wr(`ADCDO_IDX_CPLO, 8'h98);
    wr(`ADCDO_IDX_CPHI, 8'h31);
    wr(`ADCDO_IDX_PAT, ADCDO_PAT_CUSTOM);
    next_word(3);
    check("custom_word", 32'h633, rx_cmos_q);
    check("custom_shared_b", 32'h633, cmos_b_out);
    wr(`ADCDO_IDX_CTL, 8'h46);
    next_word(3);
    check("custom_separate_a", 32'h633, rx_cmos_q);
    check("separate_b", 32'h456, cmos_b_out);
    $display("test patterns done");

    wr(`ADCDO_IDX_IFSEL, 8'h80);
    next_word(3);
    check("lvds_custom", 32'h633, rx_lvds_q);
    check("lvds_dummy", 32'h0, rx_dummy_q);
    check("cmos_idle", 32'h000, cmos_a_out);
    wr(`ADCDO_IDX_PAT, ADCDO_PAT_NORMAL);
    next_word(3);
    check("lvds_data", 32'h123, rx_lvds_q);
    check("lvds_dummy_data", 32'h0, rx_dummy_q);
    check("lvds_b_odd", 32'h2E, lvds_b_out);
    wr(`ADCDO_IDX_IFSEL, 8'h00);
    wr(`ADCDO_IDX_CTL, 8'h06);
    $display("test lvds done");

    conv_a_in <= 11'h600;
    wr(`ADCDO_IDX_FGAIN, 8'h7F);
    next_word(3);
    check_near("fine_gain", 12'd1599, 12'd1, rx_cmos_q);
    wr(`ADCDO_IDX_FGAIN, 8'h00);
    wr(`ADCDO_IDX_GTC, 8'hC0);
    next_word(3);
    check_near("coarse_gain", 12'd2045, 12'd2, rx_cmos_q);
    wr(`ADCDO_IDX_GTC, 8'h00);
    $display("test gain done");

    // 27 loop steps of 16 samples needed, 520 leaves margin
    conv_a_in <= 11'h3E8;
    wr(`ADCDO_IDX_PED, 8'h18);
    wr(`ADCDO_IDX_CEN, 8'h40);
    next_word(520);
    check_near("converge_plus3", 12'd1027, 12'd1, rx_cmos_q);
    bus_xfer(1'b0, 8'h64, 8'h00, 4'hF);
    check("loop_offset", 32'h7E5, rd);
    wr(`ADCDO_IDX_PED, 8'h20);
    next_word(200);
    check_near("converge_minus4", 12'd1020, 12'd1, rx_cmos_q);
    wr(`ADCDO_IDX_CEN, 8'h00);
    next_word(3);
    check("correction_off", 32'h3E8, rx_cmos_q);
    $display("test correction done");
    give_verdict();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    $display("mismatch watchdog expected finish seen hang");
    give_verdict();
  end
endmodule
